//--- rtl/ssf_pkg.sv
package ssf_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h1;
  localparam logic [3:0] ADDR_CTRL1 = 4'h2;
  localparam logic [3:0] ADDR_CTRL2 = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h5;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
  localparam logic [3:0] ADDR_RX_SHIFT = 4'h7;

  // ************************************************************
  // Status bit positions and reset value
  // ************************************************************
  localparam int BIT_TXE = 7;
  localparam int BIT_TC = 6;
  localparam int BIT_RXF = 5;
  localparam int BIT_IDLE = 4;
  localparam int BIT_OVR = 3;
  localparam int BIT_NOISE = 2;
  localparam int BIT_FRAME = 1;
  localparam int BIT_PAR = 0;
  localparam logic [7:0] STATUS_RESET = 8'hc0;

  // ************************************************************
  // Control bit positions
  // ************************************************************
  localparam int CR1_PIE = 0;
  localparam int CR2_TIE = 7;
  localparam int CR2_TXDONE_IRQ_EN = 6;
  localparam int CR2_RIE = 5;
  localparam int CR2_IDLE_IRQ_EN = 4;

  // ************************************************************
  // Event bits of the sticky interrupt status
  // ************************************************************
  localparam int NUM_EVT = 5;
  localparam int EVT_TXE = 0;
  localparam int EVT_TC = 1;
  localparam int EVT_RX = 2;
  localparam int EVT_IDLE = 3;
  localparam int EVT_PAR = 4;
endpackage : ssf_pkg

//--- rtl/ssf_sync.sv
`timescale 1ns/1ps
// ************************************************************
// Three-stage synchroniser with agreement filter
// ************************************************************
module ssf_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin side
  input wire logic pinIn,
  // Filtered level
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  // Shift chain, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept change once stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= 1'b0;
    else if (s2 == s3)
      level <= s3;
  end
endmodule : ssf_sync

//--- rtl/ssf_flags.sv
`timescale 1ns/1ps
// Operation
// - Transmit-empty set on buffer-to-shift move
// - TXE/TC clear: status access, data write
// - No buffer move while TXE uncleared
// - TC set when data frame finishes
// - Idle or break frame leaves TC
// - Receive-ready set when word reaches data
// - Rx flags clear: status access, data read
// - Idle flag set on idle line
// - Idle rearmed only by new received word
// - Overrun when word arrives, receive-ready set
// - Overrun keeps buffer, shift overwritten
// - Noise flag, no own interrupt
// - Framing flag, no own interrupt
// - Framing plus overrun: only overrun set
// - Parity flag, enable in control one
// - Status read-only, resets to c0
// - Idle transmitter: write goes straight out
// - Busy transmitter: write held in buffer
module ssf_flags (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData,
  // Transmit shift logic
  output logic txLoad,
  output logic [7:0] txShiftData,
  input wire logic txFrameDone,
  input wire logic txFrameData,
  // Receive shift logic
  input wire logic rxWordValid,
  input wire logic [7:0] rxWord,
  input wire logic rxNoise,
  input wire logic rxFraming,
  input wire logic rxParity,
  input wire logic rxIdlePin,
  // Interrupt
  output logic irq
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] serialStatus, rxHoldingBuffer, txHoldingBuffer, ctrl1, ctrl2, rxShiftCopy;
  logic txPending, txBusy, statusSeen;
  logic idleArmed, rxIdle, rxIdleDly, idleEvent;
  logic [ssf_pkg::NUM_EVT-1:0] irqStatus, irqEnable, evt, irqClr;
  logic dataWrite, dataRead, txClear, rxClear, moveBuf, directLoad, rxAccept, overrun;

  // ************************************************************
  // Idle line input synchroniser
  // ************************************************************
  ssf_sync u_idle_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(rxIdlePin),
    .level(rxIdle)
  );

  // Rising edge of filtered idle level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rxIdleDly <= 1'b0;
    else
      rxIdleDly <= rxIdle;
  end
  assign idleEvent = rxIdle && !rxIdleDly;

  // ************************************************************
  // Access decode
  // ************************************************************
  assign dataWrite = wrStb && (addr == ssf_pkg::ADDR_DATA);
  assign dataRead = rdStb && (addr == ssf_pkg::ADDR_DATA);
  assign txClear = dataWrite && statusSeen;
  assign rxClear = dataRead && statusSeen;

  // Remember a status access until the next data access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      statusSeen <= 1'b0;
    else if (rdStb && addr == ssf_pkg::ADDR_STATUS)
      statusSeen <= 1'b1;
    else if (dataWrite || dataRead)
      statusSeen <= 1'b0;
  end

  // ************************************************************
  // Transmit path
  // ************************************************************
  // Idle transmitter loads shift register directly
  assign directLoad = dataWrite && !txBusy && !txPending;
  // Move only after transmit-empty was cleared
  assign moveBuf = txPending && (!txBusy || txFrameDone) && !serialStatus[ssf_pkg::BIT_TXE];

  // Holding buffer and pending marker
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txHoldingBuffer <= 8'h00;
      txPending <= 1'b0;
    end
    else if (dataWrite && !directLoad)
    begin
      txHoldingBuffer <= wrData;
      txPending <= 1'b1;
    end
    else if (moveBuf)
      txPending <= 1'b0;
  end

  // Shift register load toward transmit logic
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txLoad <= 1'b0;
      txShiftData <= 8'h00;
    end
    else
    begin
      txLoad <= directLoad || moveBuf;
      if (directLoad)
        txShiftData <= wrData;
      else if (moveBuf)
        txShiftData <= txHoldingBuffer;
    end
  end

  // Transmitter busy between load and frame end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      txBusy <= 1'b0;
    else if (directLoad || moveBuf)
      txBusy <= 1'b1;
    else if (txFrameDone)
      txBusy <= 1'b0;
  end

  // ************************************************************
  // Receive path
  // ************************************************************
  // Overrun when receive-ready still set
  assign overrun = rxWordValid && serialStatus[ssf_pkg::BIT_RXF];
  assign rxAccept = rxWordValid && !overrun;

  // Buffer kept on overrun, shift copy overwritten
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxHoldingBuffer <= 8'h00;
      rxShiftCopy <= 8'h00;
    end
    else
    begin
      if (rxWordValid)
        rxShiftCopy <= rxWord;
      if (rxAccept)
        rxHoldingBuffer <= rxWord;
    end
  end

  // Idle rearmed by a newly received word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      idleArmed <= 1'b1;
    else if (rxAccept)
      idleArmed <= 1'b1;
    else if (idleEvent && idleArmed)
      idleArmed <= 1'b0;
  end

  // ************************************************************
  // Status flags, set wins over clear
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      serialStatus <= ssf_pkg::STATUS_RESET;
    else
    begin
      // Transmit-empty on move into shift register
      if (directLoad || moveBuf)
        serialStatus[ssf_pkg::BIT_TXE] <= 1'b1;
      else if (txClear)
        serialStatus[ssf_pkg::BIT_TXE] <= 1'b0;
      if (txFrameDone && txFrameData)
        serialStatus[ssf_pkg::BIT_TC] <= 1'b1;
      else if (txClear)
        serialStatus[ssf_pkg::BIT_TC] <= 1'b0;
      if (rxAccept)
        serialStatus[ssf_pkg::BIT_RXF] <= 1'b1;
      else if (rxClear)
        serialStatus[ssf_pkg::BIT_RXF] <= 1'b0;
      if (idleEvent && idleArmed)
        serialStatus[ssf_pkg::BIT_IDLE] <= 1'b1;
      else if (rxClear)
        serialStatus[ssf_pkg::BIT_IDLE] <= 1'b0;
      if (overrun)
        serialStatus[ssf_pkg::BIT_OVR] <= 1'b1;
      else if (rxClear)
        serialStatus[ssf_pkg::BIT_OVR] <= 1'b0;
      if (rxAccept && rxNoise)
        serialStatus[ssf_pkg::BIT_NOISE] <= 1'b1;
      else if (rxClear)
        serialStatus[ssf_pkg::BIT_NOISE] <= 1'b0;
      if (rxAccept && rxFraming)
        serialStatus[ssf_pkg::BIT_FRAME] <= 1'b1;
      else if (rxClear)
        serialStatus[ssf_pkg::BIT_FRAME] <= 1'b0;
      if (rxAccept && rxParity)
        serialStatus[ssf_pkg::BIT_PAR] <= 1'b1;
      else if (rxClear)
        serialStatus[ssf_pkg::BIT_PAR] <= 1'b0;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1 <= 8'h00;
      ctrl2 <= 8'h00;
      irqEnable <= '0;
    end
    else if (wrStb)
    begin
      if (addr == ssf_pkg::ADDR_CTRL1)
        ctrl1 <= wrData;
      if (addr == ssf_pkg::ADDR_CTRL2)
        ctrl2 <= wrData;
      if (addr == ssf_pkg::ADDR_IRQ_EN)
        irqEnable <= wrData[ssf_pkg::NUM_EVT-1:0];
    end
  end

  // ************************************************************
  // Interrupt events and sticky status
  // ************************************************************
  // Flag set conditions gated by their own enables; receive event fires on any arriving word, overrun included
  always_comb
  begin
    evt = '0;
    evt[ssf_pkg::EVT_TXE] = (directLoad || moveBuf) && ctrl2[ssf_pkg::CR2_TIE];
    evt[ssf_pkg::EVT_TC] = txFrameDone && txFrameData && ctrl2[ssf_pkg::CR2_TXDONE_IRQ_EN];
    evt[ssf_pkg::EVT_RX] = rxWordValid && ctrl2[ssf_pkg::CR2_RIE];
    evt[ssf_pkg::EVT_IDLE] = idleEvent && idleArmed && ctrl2[ssf_pkg::CR2_IDLE_IRQ_EN];
    evt[ssf_pkg::EVT_PAR] = rxAccept && rxParity && ctrl1[ssf_pkg::CR1_PIE];
  end

  assign irqClr = (wrStb && addr == ssf_pkg::ADDR_IRQ_CLR) ? wrData[ssf_pkg::NUM_EVT-1:0] : '0;

  // Sticky bits, set wins over clear
  generate
    for (genvar i = 0; i < ssf_pkg::NUM_EVT; i++)
    begin : g_evt
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          irqStatus[i] <= 1'b0;
        else if (evt[i])
          irqStatus[i] <= 1'b1;
        else if (irqClr[i])
          irqStatus[i] <= 1'b0;
      end
    end
  endgenerate

  assign irq = |(irqStatus & irqEnable);

  // ************************************************************
  // Read data, one cycle after strobe
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData <= 8'h00;
    else if (rdStb)
    begin
      case (addr)
        ssf_pkg::ADDR_STATUS: rdData <= serialStatus;
        ssf_pkg::ADDR_DATA: rdData <= rxHoldingBuffer;
        ssf_pkg::ADDR_CTRL1: rdData <= ctrl1;
        ssf_pkg::ADDR_CTRL2: rdData <= ctrl2;
        ssf_pkg::ADDR_IRQ_STAT: rdData <= {3'h0, irqStatus};
        ssf_pkg::ADDR_IRQ_EN: rdData <= {3'h0, irqEnable};
        ssf_pkg::ADDR_RX_SHIFT: rdData <= rxShiftCopy;
        default: rdData <= 8'h00;
      endcase
    end
    else
      rdData <= 8'h00;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_status_rd;
    rdStb && addr == ssf_pkg::ADDR_STATUS;
  endsequence
  sequence s_data_wr;
    wrStb && addr == ssf_pkg::ADDR_DATA;
  endsequence
  sequence s_tx_tail;
    s_data_wr and (!directLoad && !moveBuf && !txFrameDone);
  endsequence

  a_txe_on_load: assert property (@(posedge clk) disable iff (!rst_n)
    (directLoad || moveBuf) |=> serialStatus[ssf_pkg::BIT_TXE])
    else $error("tx empty not set on load");
  a_tx_clear_seq: assert property (@(posedge clk) disable iff (!rst_n)
    ((s_status_rd ##1 s_tx_tail) or (s_status_rd ##1 (!dataWrite && !dataRead) ##1 s_tx_tail))
      |=> !serialStatus[ssf_pkg::BIT_TXE] && !serialStatus[ssf_pkg::BIT_TC])
    else $error("tx flags not cleared by sequence");
  a_no_early_move: assert property (@(posedge clk) disable iff (!rst_n)
    (txPending && serialStatus[ssf_pkg::BIT_TXE]) |=> txPending)
    else $error("buffer moved while tx empty set");
  a_tc_data_only: assert property (@(posedge clk) disable iff (!rst_n)
    (txFrameDone && !txFrameData && !txClear) |=> $stable(serialStatus[ssf_pkg::BIT_TC]))
    else $error("tc changed on idle or break frame");
  a_rx_ready_set: assert property (@(posedge clk) disable iff (!rst_n)
    rxAccept |=> serialStatus[ssf_pkg::BIT_RXF] && rxHoldingBuffer == $past(rxWord))
    else $error("receive ready not set");
  a_overrun_keep: assert property (@(posedge clk) disable iff (!rst_n)
    overrun |=> serialStatus[ssf_pkg::BIT_OVR] && $stable(rxHoldingBuffer))
    else $error("overrun lost buffer");
  a_frame_overrun: assert property (@(posedge clk) disable iff (!rst_n)
    (overrun && rxFraming && !serialStatus[ssf_pkg::BIT_FRAME]) |=> !serialStatus[ssf_pkg::BIT_FRAME])
    else $error("framing set with overrun");
  a_idle_rearm: assert property (@(posedge clk) disable iff (!rst_n)
    (!idleArmed && !rxAccept) |=> !$rose(serialStatus[ssf_pkg::BIT_IDLE]))
    else $error("idle set without new word");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    (!irq && evt == '0 && !(wrStb && addr == ssf_pkg::ADDR_IRQ_EN)) |=> !irq)
    else $error("interrupt level wrong");
endmodule : ssf_flags

//--- test/ssf_far_node.sv
`timescale 1ns/1ps
// ************************************************************
// Far-end shifter model
// ************************************************************
module ssf_far_node #(
  parameter int FRAME_LEN = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Transmit side
  input wire logic txLoad,
  input wire logic breakFrame,
  output logic txFrameDone,
  output logic txFrameData,
  // Receive side
  input wire logic rxGo,
  input wire logic [7:0] rxByte,
  input wire logic [2:0] rxErr,
  output logic rxWordValid,
  output logic [7:0] rxWord,
  output logic rxNoise,
  output logic rxFraming,
  output logic rxParity
);
  int txCount;

  // Frame timer, done pulse at end of frame
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txCount <= 0;
      txFrameDone <= 1'b0;
      txFrameData <= 1'b0;
    end
    else
    begin
      txFrameDone <= 1'b0;
      txFrameData <= ~txFrameData; // Meaningless outside done
      if (txLoad)
        txCount <= FRAME_LEN;
      else if (txCount != 0)
      begin
        txCount <= txCount - 1;
        if (txCount == 1)
        begin
          txFrameDone <= 1'b1;
          txFrameData <= ~breakFrame;
        end
      end
    end
  end

  // Received word handed over for one cycle, garbage otherwise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxWordValid <= 1'b0;
      rxWord <= 8'h00;
      {rxNoise, rxFraming, rxParity} <= 3'h0;
    end
    else
    begin
      rxWordValid <= rxGo;
      rxWord <= rxGo ? rxByte : ~rxWord;
      {rxNoise, rxFraming, rxParity} <= rxGo ? rxErr : ~{rxNoise, rxFraming, rxParity};
    end
  end
endmodule : ssf_far_node

//--- test/test_serial_status_flag_logic.sv
`timescale 1ns/1ps
module test_serial_status_flag_logic;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [7:0] rdData;
  logic txLoad, txFrameDone, txFrameData, rxWordValid, rxNoise, rxFraming, rxParity, irq;
  logic [7:0] txShiftData, rxWord;
  logic rxIdlePin = 1'b0;
  logic breakFrame = 1'b1;
  logic rxGo = 1'b0;
  logic [7:0] rxByte = 8'h00;
  logic [2:0] rxErr = 3'h0;
  logic [7:0] v;
  int nErrors = 0;
  int checks = 0;
  int loads = 0;
  int cycles = 0;
  int seen;

  // Clock
  always #20 clk = ~clk;

  ssf_flags ssf_flags_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .txLoad(txLoad), .txShiftData(txShiftData), .txFrameDone(txFrameDone),
    .txFrameData(txFrameData), .rxWordValid(rxWordValid), .rxWord(rxWord), .rxNoise(rxNoise),
    .rxFraming(rxFraming), .rxParity(rxParity), .rxIdlePin(rxIdlePin), .irq(irq));

  ssf_far_node #(.FRAME_LEN(16)) ssf_far_node_inst (.clk(clk), .rst_n(rst_n), .txLoad(txLoad),
    .breakFrame(breakFrame), .txFrameDone(txFrameDone), .txFrameData(txFrameData), .rxGo(rxGo),
    .rxByte(rxByte), .rxErr(rxErr), .rxWordValid(rxWordValid), .rxWord(rxWord), .rxNoise(rxNoise),
    .rxFraming(rxFraming), .rxParity(rxParity));

  // Load pulse counter and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (txLoad === 1'b1)
      loads++;
    if (cycles == 20000)
    begin
      nErrors++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 v = rdData;
  endtask : rd

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input string what);
    rd(a);
    check(what, v, exp);
  endtask : rdChk

  // Waits for a load pulse (0) or a frame end (1)
  task automatic waitFor(input int which);
    int i;
    for (i = 0; i < 200; i++)
    begin
      @(posedge clk);
      if ((which == 0 && txLoad === 1'b1) || (which == 1 && txFrameDone === 1'b1))
        break;
    end
    if (i == 200)
      check("handshake wait", 8'h00, 8'h01);
  endtask : waitFor

  task automatic sendRx(input logic [7:0] b, input logic [2:0] e);
    @(posedge clk);
    rxGo <= 1'b1;
    rxByte <= b;
    rxErr <= e;
    @(posedge clk);
    rxGo <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : sendRx

  task automatic idlePulse;
    rxIdlePin <= 1'b0;
    repeat (8) @(posedge clk);
    rxIdlePin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : idlePulse

  // ************************************************************
  // Tests
  // ************************************************************
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(ssf_pkg::ADDR_STATUS, ssf_pkg::STATUS_RESET, "status after reset");
    wr(ssf_pkg::ADDR_STATUS, 8'h00);
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "status after write");
    check("irq after reset", {7'h00, irq}, 8'h00);
    wr(ssf_pkg::ADDR_CTRL1, 8'h01);
    wr(ssf_pkg::ADDR_CTRL2, 8'hf0);
    wr(ssf_pkg::ADDR_IRQ_EN, 8'h1f);
    rdChk(ssf_pkg::ADDR_CTRL1, 8'h01, "control one readback");
    rdChk(ssf_pkg::ADDR_CTRL2, 8'hf0, "control two readback");
    rdChk(ssf_pkg::ADDR_IRQ_EN, 8'h1f, "enable readback");
    $display("Test reset done");
    wr(ssf_pkg::ADDR_DATA, 8'h11);
    waitFor(0);
    check("direct load word", txShiftData, 8'h11);
    rdChk(ssf_pkg::ADDR_STATUS, 8'h80, "status after direct load");
    rd(ssf_pkg::ADDR_DATA);
    wr(ssf_pkg::ADDR_DATA, 8'h22);
    rdChk(ssf_pkg::ADDR_STATUS, 8'h80, "write without status access");
    rd(ssf_pkg::ADDR_DATA);
    seen = loads;
    waitFor(1);
    repeat (10) @(posedge clk);
    check("loads while empty flag set", 8'(loads - seen), 8'h00);
    rdChk(ssf_pkg::ADDR_STATUS, 8'h80, "status after break frame");
    rd(ssf_pkg::ADDR_DATA);
    breakFrame <= 1'b0;
    rd(ssf_pkg::ADDR_STATUS);
    wr(ssf_pkg::ADDR_DATA, 8'h33);
    waitFor(0);
    check("pending word moved", txShiftData, 8'h33);
    rd(ssf_pkg::ADDR_STATUS);
    wr(ssf_pkg::ADDR_DATA, 8'h44);
    rdChk(ssf_pkg::ADDR_STATUS, 8'h00, "status with word held");
    waitFor(1);
    waitFor(0);
    check("held word loaded", txShiftData, 8'h44);
    waitFor(1);
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "status after data frame");
    rd(ssf_pkg::ADDR_DATA);
    rdChk(ssf_pkg::ADDR_IRQ_STAT, 8'h03, "transmit events");
    $display("Test transmit done");
    wr(ssf_pkg::ADDR_IRQ_CLR, 8'h1f);
    rdChk(ssf_pkg::ADDR_IRQ_STAT, 8'h00, "sticky after clear");
    check("irq after clear", {7'h00, irq}, 8'h00);
    wr(ssf_pkg::ADDR_IRQ_EN, 8'h00);
    sendRx(8'h5a, 3'h0);
    check("irq masked", {7'h00, irq}, 8'h00);
    rdChk(ssf_pkg::ADDR_IRQ_STAT, 8'h04, "sticky receive event");
    wr(ssf_pkg::ADDR_IRQ_EN, 8'h1f);
    check("irq unmasked", {7'h00, irq}, 8'h01);
    wr(ssf_pkg::ADDR_IRQ_CLR, 8'h04);
    check("irq cleared", {7'h00, irq}, 8'h00);
    $display("Test interrupt done");
    rdChk(ssf_pkg::ADDR_STATUS, 8'he0, "receive ready");
    rdChk(ssf_pkg::ADDR_DATA, 8'h5a, "received word");
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "receive flags cleared");
    sendRx(8'h3c, 3'h7);
    rdChk(ssf_pkg::ADDR_STATUS, 8'he7, "error flags");
    rdChk(ssf_pkg::ADDR_IRQ_STAT, 8'h14, "parity and receive events");
    rdChk(ssf_pkg::ADDR_STATUS, 8'he7, "status before clear");
    rdChk(ssf_pkg::ADDR_DATA, 8'h3c, "word with errors");
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "error flags cleared");
    wr(ssf_pkg::ADDR_IRQ_CLR, 8'h1f);
    sendRx(8'h61, 3'h0);
    sendRx(8'h62, 3'h2);
    rdChk(ssf_pkg::ADDR_STATUS, 8'he8, "overrun only");
    rdChk(ssf_pkg::ADDR_DATA, 8'h61, "buffer kept on overrun");
    rdChk(ssf_pkg::ADDR_RX_SHIFT, 8'h62, "shift word overwritten");
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "overrun cleared");
    $display("Test receive done");
    idlePulse();
    rdChk(ssf_pkg::ADDR_STATUS, 8'hd0, "idle line seen");
    rdChk(ssf_pkg::ADDR_IRQ_STAT, 8'h0c, "idle and receive events");
    rd(ssf_pkg::ADDR_DATA);
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "idle cleared");
    idlePulse();
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "idle not rearmed");
    sendRx(8'h77, 3'h0);
    idlePulse();
    rdChk(ssf_pkg::ADDR_STATUS, 8'hf0, "idle rearmed by word");
    $display("Test idle done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(ssf_pkg::ADDR_STATUS, 8'hc0, "status after second reset");
    $display("Test second reset done");
    tally_and_finish();
  end
endmodule : test_serial_status_flag_logic
